// ==== rtl/wdtw_cfg.svh ====
// Constants of the windowed watchdog: timing, register map and fields.
// What this block does
// [RULE1] Counter runs from low-power RC, enabled together.
// [RULE2] Prescaler divides RC clock by 32 or 128.
// [RULE3] Prescale select one means 128, zero 32.
// [RULE4] Base timeout 1 ms or 4 ms.
// [RULE5] Four-bit postscale field picks sixteen ratios.
// [RULE6] Postscale code n divides by two^n.
// [RULE7] Device reset or clock switch restarts counters.
// [RULE8] Entering or leaving sleep/idle restarts counters.
// [RULE9] Kick instruction restarts the timeout period.
// [RULE10] Timeout in sleep/idle wakes, no reset.
// [RULE11] Software clears sleep and idle bits.
// [RULE12] Hard enable fuse forces watchdog running.
// [RULE13] Otherwise soft enable bit five runs it.
// [RULE14] Every device reset clears soft enable.
// [RULE15] Early kick in window mode resets device.
// [RULE16] Timeout sets sticky flag, software clears.
// [RULE17] Timeout while running resets the device.
`ifndef WDTW_CFG_SVH
`define WDTW_CFG_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define WDTW_REF_HZ        100000000
`define WDTW_LOW_POWER_RC_OSC_HZ       32000
`define WDTW_TICK_CYCLES   (`WDTW_REF_HZ / `WDTW_LOW_POWER_RC_OSC_HZ)
`define WDTW_BASE_US_DIV32  1000
`define WDTW_BASE_US_DIV128 4000
`define WDTW_PRE32_LEN  (`WDTW_BASE_US_DIV32 * (`WDTW_LOW_POWER_RC_OSC_HZ / 1000) / 1000)
`define WDTW_PRE128_LEN (`WDTW_BASE_US_DIV128 * (`WDTW_LOW_POWER_RC_OSC_HZ / 1000) / 1000)
`define WDTW_CNT_W     23

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define WDTW_ADDR_RESET_CTRL 4'h0
`define WDTW_ADDR_CONFIG     4'h1
`define WDTW_ADDR_INT_STAT   4'h2
`define WDTW_ADDR_INT_CLR    4'h3
`define WDTW_ADDR_INT_EN     4'h4

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define WDTW_RC_IDLE     2
`define WDTW_RC_SLEEP    3
`define WDTW_RC_TMO      4
`define WDTW_RC_SWEN     5
`define WDTW_CFG_POST_HI 3
`define WDTW_CFG_PRE     4
`define WDTW_CFG_WINDOW_DISABLE_BIT  6
`define WDTW_CFG_HARDEN  7
`define WDTW_CFG_RESET   8'h5f
`define WDTW_EV_TMO      0
`define WDTW_EV_WIN      1
`define WDTW_EV_WAKE     2
`define WDTW_EV_N        3

`endif

// ==== rtl/wdtw_pkg.sv ====
// Types shared by the windowed watchdog modules.
package wdtw_pkg;
  typedef enum logic [1:0] {
    WDTW_RUN   = 2'b00,
    WDTW_SLEEP = 2'b01,
    WDTW_IDLE  = 2'b10
  } wdtw_mode_t;
  typedef logic [15:0] wdtw_word_t;
  typedef logic [3:0]  wdtw_addr_t;
endpackage

// ==== rtl/wdtw_osc_if.sv ====
// Enable and tick carrier between the watchdog and its RC clock source.
`timescale 1ns/1ps
interface wdtw_osc_if;
  logic osc_en;
  logic tick;
  modport ctrl (output osc_en, input tick);
  modport osc  (input osc_en, output tick);
endinterface

// ==== rtl/wdtw_low_power_rc_osc_osc.sv ====
// Low-power RC clock model: one tick per nominal 32 kHz period.
`timescale 1ns/1ps
module wdtw_low_power_rc_osc_osc #(
  parameter int TICK_CYCLES = 3125
) (
  // Clock and reset.
  input  wire logic  ref_clk_in,
  input  wire logic  nrst_in,
  // Watchdog side.
  wdtw_osc_if.osc    osc
);
  import wdtw_pkg::*;

  logic [15:0] div_cnt;

  // The source only runs while enabled, which saves power when idle.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_cnt  <= 16'h0000;
      osc.tick <= 1'b0;
    end else if (!osc.osc_en) begin
      div_cnt  <= 16'h0000; // [RULE1]
      osc.tick <= 1'b0;
    end else if (div_cnt == 16'(TICK_CYCLES - 1)) begin
      div_cnt  <= 16'h0000;
      osc.tick <= 1'b1;
    end else begin
      div_cnt  <= div_cnt + 16'h0001;
      osc.tick <= 1'b0;
    end
  end

  property p_tick_only_enabled;
    @(posedge ref_clk_in) disable iff (!nrst_in)
      osc.tick |-> $past(osc.osc_en);
  endproperty
  a_tick_only_enabled: assert property (p_tick_only_enabled) // [RULE1]
    else $error("RC tick while source disabled");
endmodule

// ==== rtl/wdtw_top.sv ====
// Windowed watchdog timer with sleep wake-up and register port.
`timescale 1ns/1ps
`include "wdtw_cfg.svh"
module wdtw_top #(
  parameter int TICK_CYCLES = `WDTW_TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic              REF_CLK_IN,
  input  wire logic              NRST_IN,
  // Register port.
  input  wire wdtw_pkg::wdtw_addr_t ADDR_IN,
  input  wire wdtw_pkg::wdtw_word_t WDATA_IN,
  input  wire logic              WR_IN,
  input  wire logic              RD_IN,
  output wdtw_pkg::wdtw_word_t   RDATA_OUT,
  // Core events.
  input  wire logic              KICK_IN,
  input  wire logic              SLEEP_ENTER_IN,
  input  wire logic              IDLE_ENTER_IN,
  input  wire logic              WAKE_IN,
  input  wire logic              CLK_SWITCH_DONE_IN,
  // Results.
  output logic                   RESET_OUT,
  output logic                   WAKE_OUT,
  output logic                   LOW_POWER_RC_OSC_EN_OUT,
  output logic                   IRQ_OUT
);
  import wdtw_pkg::*;

  localparam int CW = `WDTW_CNT_W;

  wdtw_osc_if osc_if ();

  wdtw_mode_t       mode;
  logic [7:0]       cfg;
  logic             soft_en;
  logic             rc_idle;
  logic             rc_sleep;
  logic             rc_tmo;
  logic [`WDTW_EV_N-1:0] int_stat;
  logic [`WDTW_EV_N-1:0] int_en;
  logic [CW-1:0]    cnt;
  logic [CW-1:0]    pre_len;
  logic [CW-1:0]    period;
  logic             wdt_en;
  logic             window_open;
  logic             timeout;
  logic             run;
  logic             pwrsave_go;
  logic             wake_go;
  logic             kick_run;
  logic             win_viol;
  logic             dev_rst;
  logic             restart;
  logic             wr_rc;
  logic             wr_cfg;
  logic             wr_clr;
  logic             wr_en;
  logic [`WDTW_EV_N-1:0] events;
  logic [`WDTW_EV_N-1:0] next_int_stat;

  // ----------------------------------------------------------------------
  // RC clock source
  // ----------------------------------------------------------------------
  wdtw_low_power_rc_osc_osc #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_osc (
    .ref_clk_in (REF_CLK_IN),
    .nrst_in    (NRST_IN),
    .osc        (osc_if.osc)
  );

  // The fuse forces the timer on; otherwise the soft bit decides.
  assign wdt_en        = cfg[`WDTW_CFG_HARDEN] | soft_en; // [RULE12] [RULE13]
  assign osc_if.osc_en = wdt_en; // [RULE1]

  // ----------------------------------------------------------------------
  // Timeout arithmetic
  // ----------------------------------------------------------------------
  // The low bits of the counter act as the prescaler, the rest as the
  // postscaler, so one comparison covers both stages.
  assign pre_len = cfg[`WDTW_CFG_PRE]            // [RULE3]
                   ? CW'(`WDTW_PRE128_LEN)       // [RULE2]
                   : CW'(`WDTW_PRE32_LEN);       // [RULE4]
  assign period  = pre_len << cfg[`WDTW_CFG_POST_HI:0]; // [RULE5] [RULE6]
  assign window_open = cnt >= (period - (period >> 2)); // [RULE15]
  assign timeout = wdt_en && osc_if.tick && (cnt == period - CW'(1));

  assign run        = (mode == WDTW_RUN);
  assign pwrsave_go = run && (SLEEP_ENTER_IN || IDLE_ENTER_IN);
  assign wake_go    = !run && (timeout || WAKE_IN);
  assign kick_run   = run && KICK_IN;
  assign win_viol   = kick_run && wdt_en && !cfg[`WDTW_CFG_WINDOW_DISABLE_BIT]
                      && !window_open; // [RULE15]
  assign dev_rst    = run && (timeout || win_viol); // [RULE17]

  // Every restart source clears both stages at once.
  assign restart = CLK_SWITCH_DONE_IN            // [RULE7]
                   || pwrsave_go || wake_go      // [RULE8]
                   || kick_run                   // [RULE9]
                   || timeout || dev_rst || !wdt_en;

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  // Counting carries on in sleep and idle; only the enable gates it.
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cnt <= '0; // [RULE7]
    end else if (restart) begin
      cnt <= '0;
    end else if (osc_if.tick) begin
      cnt <= cnt + CW'(1); // [RULE10]
    end
  end

  // ----------------------------------------------------------------------
  // Power mode
  // ----------------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      mode <= WDTW_RUN;
    end else begin
      case (mode)
        WDTW_RUN: begin
          if (SLEEP_ENTER_IN) begin
            mode <= WDTW_SLEEP;
          end else if (IDLE_ENTER_IN) begin
            mode <= WDTW_IDLE;
          end
        end
        WDTW_SLEEP, WDTW_IDLE: begin
          if (wake_go) begin
            mode <= WDTW_RUN; // [RULE10]
          end
        end
        default: begin
          mode <= WDTW_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  always_comb begin
    wr_rc  = 1'b0;
    wr_cfg = 1'b0;
    wr_clr = 1'b0;
    wr_en  = 1'b0;
    if (WR_IN && ADDR_IN == `WDTW_ADDR_RESET_CTRL) begin
      wr_rc = 1'b1;
    end else if (WR_IN && ADDR_IN == `WDTW_ADDR_CONFIG) begin
      wr_cfg = 1'b1;
    end else if (WR_IN && ADDR_IN == `WDTW_ADDR_INT_CLR) begin
      wr_clr = 1'b1;
    end else if (WR_IN && ADDR_IN == `WDTW_ADDR_INT_EN) begin
      wr_en = 1'b1;
    end
  end

  // Configuration word stands in for the fuses and loads its default.
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cfg <= `WDTW_CFG_RESET;
    end else if (wr_cfg) begin
      cfg <= WDATA_IN[7:0];
    end
  end

  // Soft enable drops on every device reset, including our own.
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      soft_en <= 1'b0; // [RULE14]
    end else if (dev_rst) begin
      soft_en <= 1'b0; // [RULE14]
    end else if (wr_rc) begin
      soft_en <= WDATA_IN[`WDTW_RC_SWEN]; // [RULE13]
    end
  end

  // Status bits: hardware set wins over a clearing write in one cycle.
  // The sleep and idle bits stay set after a wake; software clears them.
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rc_tmo   <= 1'b0;
      rc_sleep <= 1'b0;
      rc_idle  <= 1'b0;
    end else begin
      if (timeout) begin
        rc_tmo <= 1'b1; // [RULE16]
      end else if (wr_rc) begin
        rc_tmo <= WDATA_IN[`WDTW_RC_TMO];
      end
      if (pwrsave_go && SLEEP_ENTER_IN) begin
        rc_sleep <= 1'b1; // [RULE11]
      end else if (wr_rc) begin
        rc_sleep <= WDATA_IN[`WDTW_RC_SLEEP];
      end
      if (pwrsave_go && !SLEEP_ENTER_IN) begin
        rc_idle <= 1'b1;
      end else if (wr_rc) begin
        rc_idle <= WDATA_IN[`WDTW_RC_IDLE];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  assign events[`WDTW_EV_TMO]  = timeout;
  assign events[`WDTW_EV_WIN]  = win_viol;
  assign events[`WDTW_EV_WAKE] = wake_go;

  always_comb begin
    next_int_stat = int_stat;
    if (wr_clr) begin
      next_int_stat = int_stat & ~WDATA_IN[`WDTW_EV_N-1:0];
    end
    next_int_stat = next_int_stat | events;
  end

  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      int_stat <= '0;
      int_en   <= '0;
    end else begin
      int_stat <= next_int_stat;
      if (wr_en) begin
        int_en <= WDATA_IN[`WDTW_EV_N-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Reset and wake leave as single-cycle pulses from flops.
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      RESET_OUT   <= 1'b0;
      WAKE_OUT    <= 1'b0;
      LOW_POWER_RC_OSC_EN_OUT <= 1'b0;
      IRQ_OUT     <= 1'b0;
    end else begin
      RESET_OUT   <= dev_rst; // [RULE15] [RULE17]
      WAKE_OUT    <= !run && timeout; // [RULE10]
      LOW_POWER_RC_OSC_EN_OUT <= wdt_en; // [RULE1]
      IRQ_OUT     <= |(int_stat & int_en);
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      RDATA_OUT <= 16'h0000;
    end else if (!RD_IN) begin
      RDATA_OUT <= 16'h0000;
    end else if (ADDR_IN == `WDTW_ADDR_RESET_CTRL) begin
      RDATA_OUT <= 16'h0000;
      RDATA_OUT[`WDTW_RC_IDLE]  <= rc_idle;
      RDATA_OUT[`WDTW_RC_SLEEP] <= rc_sleep;
      RDATA_OUT[`WDTW_RC_TMO]   <= rc_tmo;
      RDATA_OUT[`WDTW_RC_SWEN]  <= soft_en;
    end else if (ADDR_IN == `WDTW_ADDR_CONFIG) begin
      RDATA_OUT <= {8'h00, cfg};
    end else if (ADDR_IN == `WDTW_ADDR_INT_STAT) begin
      RDATA_OUT <= 16'(int_stat);
    end else if (ADDR_IN == `WDTW_ADDR_INT_EN) begin
      RDATA_OUT <= 16'(int_en);
    end else begin
      RDATA_OUT <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!NRST_IN);

  sequence s_wake_done;
    WAKE_OUT && !RESET_OUT ##0 mode == WDTW_RUN;
  endsequence

  property p_harden;
    cfg[`WDTW_CFG_HARDEN] |-> wdt_en ##1 LOW_POWER_RC_OSC_EN_OUT;
  endproperty
  a_harden: assert property (p_harden) // [RULE12]
    else $error("Hard enable did not force the watchdog on");

  property p_soft_only;
    !cfg[`WDTW_CFG_HARDEN] && !soft_en |-> !wdt_en;
  endproperty
  a_soft_only: assert property (p_soft_only) // [RULE13]
    else $error("Watchdog ran without any enable");

  property p_period;
    timeout |-> period == ((cfg[`WDTW_CFG_PRE] ? 128 : 32)
                           << cfg[`WDTW_CFG_POST_HI:0])
                && cnt == period - CW'(1);
  endproperty
  a_period: assert property (p_period) // [RULE4]
    else $error("Timeout at the wrong count");

  property p_run_reset;
    timeout && run |=> RESET_OUT && rc_tmo && cnt == 0;
  endproperty
  a_run_reset: assert property (p_run_reset) // [RULE17]
    else $error("Running timeout gave no device reset");

  property p_sleep_wake;
    timeout && !run |=> s_wake_done;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) // [RULE10]
    else $error("Sleep timeout did not wake cleanly");

  property p_window;
    KICK_IN && run && wdt_en && !cfg[`WDTW_CFG_WINDOW_DISABLE_BIT] && !window_open
      |=> RESET_OUT && int_stat[`WDTW_EV_WIN];
  endproperty
  a_window: assert property (p_window) // [RULE15]
    else $error("Early kick did not reset the device");

  property p_kick;
    KICK_IN && run |=> cnt == 0 ##1 cnt <= 1;
  endproperty
  a_kick: assert property (p_kick) // [RULE9]
    else $error("Kick did not restart the period");

  property p_pwrsave;
    pwrsave_go |=> cnt == 0 && !run;
  endproperty
  a_pwrsave: assert property (p_pwrsave) // [RULE8]
    else $error("Power-save entry did not restart the counter");

  property p_clk_switch;
    CLK_SWITCH_DONE_IN |=> cnt == 0;
  endproperty
  a_clk_switch: assert property (p_clk_switch) // [RULE7]
    else $error("Clock switch did not restart the counter");

  property p_tmo_sticky;
    rc_tmo && !(wr_rc && !WDATA_IN[`WDTW_RC_TMO]) |=> rc_tmo;
  endproperty
  a_tmo_sticky: assert property (p_tmo_sticky) // [RULE16]
    else $error("Timeout flag cleared without a write");

  property p_swen_drop;
    RESET_OUT |-> !soft_en;
  endproperty
  a_swen_drop: assert property (p_swen_drop) // [RULE14]
    else $error("Soft enable survived a watchdog reset");
endmodule

// ==== dv/wdtw_tb.sv ====
// Self-checking testbench of the windowed watchdog through its ports.
`timescale 1ns/1ps
`include "wdtw_cfg.svh"
module testbench;
  import wdtw_pkg::*;

  // ----------------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------------
  localparam int TICK = 4;    // Short tick keeps each timeout at 512 cycles or fewer.
  localparam int KICK = 0;
  localparam int SLP  = 1;
  localparam int IDL  = 2;
  localparam int WAKE = 3;
  localparam int CSW  = 4;
  logic       ref_clk;
  logic       nrst;
  wdtw_addr_t addr;
  wdtw_word_t wdata;
  logic       wr_s;
  logic       rd_s;
  logic [4:0] ev;
  wdtw_word_t rdata;
  logic       rst_o;
  logic       wake_o;
  logic       osc_o;
  logic       irq_o;
  int         fails;
  int         checked;
  int         cyc;
  wdtw_word_t v;
  logic [7:0] cfgs [4] = '{8'h40, 8'h41, 8'h42, 8'h50};

  wdtw_top #(.TICK_CYCLES(TICK)) dut (
    .REF_CLK_IN(ref_clk), .NRST_IN(nrst), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata), .KICK_IN(ev[KICK]),
    .SLEEP_ENTER_IN(ev[SLP]), .IDLE_ENTER_IN(ev[IDL]), .WAKE_IN(ev[WAKE]),
    .CLK_SWITCH_DONE_IN(ev[CSW]), .RESET_OUT(rst_o), .WAKE_OUT(wake_o),
    .LOW_POWER_RC_OSC_EN_OUT(osc_o), .IRQ_OUT(irq_o));

  // ----------------------------------------------------------------------
  // Clock, hang guard and closing report
  // ----------------------------------------------------------------------
  // Clock at 100 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d.", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // The whole sequence needs about 3k cycles, so 30k means a hang.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc >= 30000) begin
      fails++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, exp, input logic ok);
    checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input wdtw_addr_t a, input wdtw_word_t d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge ref_clk);
    wr_s  <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input wdtw_addr_t a);
    @(posedge ref_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge ref_clk);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic rd_chk(input wdtw_addr_t a, input wdtw_word_t e);
    rd(a);
    chk(v, e, v === e);
  endtask

  task automatic pulse(input int i);
    @(posedge ref_clk);
    ev[i] <= 1'b1;
    @(posedge ref_clk);
    ev[i] <= 1'b0;
  endtask

  // Load the configuration, clear old status and set the soft enable.
  task automatic arm(input logic [7:0] c);
    wr(`WDTW_ADDR_CONFIG, {8'h00, c});
    wr(`WDTW_ADDR_INT_CLR, 16'h0007);
    wr(`WDTW_ADDR_RESET_CTRL, 16'h0020);
    @(posedge ref_clk);
    #1 chk(osc_o, 1, osc_o === 1'b1);
  endtask

  // Waits for reset or wake; tick phase is unknown, hence the margin.
  // A pulse launched at the edge where the caller returns is seen too.
  task automatic wait_ev(input logic want_wake, input int exp);
    int   n;
    logic hit;
    n   = 0;
    #1 hit = (rst_o === 1'b1) || (wake_o === 1'b1);
    while (!hit && n < exp + 16) begin
      @(posedge ref_clk);
      #1 n++;
      hit = (rst_o === 1'b1) || (wake_o === 1'b1);
    end
    chk(n, exp, hit && n >= exp - 8 && n <= exp + 8);
    chk(wake_o, want_wake, wake_o === want_wake && rst_o === !want_wake);
    @(posedge ref_clk);
    #1 chk({rst_o, wake_o}, 0, {rst_o, wake_o} === 2'b00);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    addr = '0;
    wdata = '0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    ev = '0;
    fails = 0;
    checked = 0;
    cyc = 0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    // Reset values, unmapped and write-only places read as zero.
    rd_chk(`WDTW_ADDR_RESET_CTRL, 16'h0000);
    rd_chk(`WDTW_ADDR_CONFIG, 16'h005f);
    rd_chk(`WDTW_ADDR_INT_STAT, 16'h0000);
    rd_chk(`WDTW_ADDR_INT_CLR, 16'h0000);
    rd_chk(4'hf, 16'h0000);
    chk(osc_o, 0, osc_o === 1'b0);
    wr(`WDTW_ADDR_INT_EN, 16'h0007);
    // Prescale and postscale ratios measured as the timeout length.
    foreach (cfgs[i]) begin
      arm(cfgs[i]);
      wait_ev(0, TICK * ((cfgs[i][4] ? 128 : 32)
                         << cfgs[i][3:0]));
    end
    // Sticky flag, cleared soft enable and the interrupt path.
    rd_chk(`WDTW_ADDR_RESET_CTRL, 16'h0010);
    rd_chk(`WDTW_ADDR_INT_STAT, 16'h0001);
    chk(irq_o, 1, irq_o === 1'b1);
    wr(`WDTW_ADDR_INT_EN, 16'h0000);
    repeat (2) @(posedge ref_clk);
    #1 chk(irq_o, 0, irq_o === 1'b0);
    wr(`WDTW_ADDR_INT_EN, 16'h0007);
    repeat (2) @(posedge ref_clk);
    #1 chk(irq_o, 1, irq_o === 1'b1);
    wr(`WDTW_ADDR_INT_CLR, 16'h0001);
    repeat (2) @(posedge ref_clk);
    #1 chk(irq_o, 0, irq_o === 1'b0);
    rd_chk(`WDTW_ADDR_RESET_CTRL, 16'h0010);
    wr(`WDTW_ADDR_RESET_CTRL, 16'h0000);
    rd_chk(`WDTW_ADDR_RESET_CTRL, 16'h0000);
    // A kick restarts the period.
    arm(8'h40);
    repeat (100) @(posedge ref_clk);
    pulse(KICK);
    wait_ev(0, 128);
    // Window mode: early kick resets, late kick restarts.
    arm(8'h00);
    repeat (20) @(posedge ref_clk);
    pulse(KICK);
    wait_ev(0, 1);
    rd(`WDTW_ADDR_INT_STAT);
    chk(v[1], 1, v[1] === 1'b1);
    arm(8'h00);
    repeat (110) @(posedge ref_clk);
    pulse(KICK);
    wait_ev(0, 128);
    // Timeout in sleep wakes the core instead of resetting it.
    arm(8'h40);
    repeat (60) @(posedge ref_clk);
    pulse(SLP);
    wait_ev(1, 128);
    rd_chk(`WDTW_ADDR_RESET_CTRL, 16'h0038);
    rd(`WDTW_ADDR_INT_STAT);
    chk(v[2], 1, v[2] === 1'b1);
    wr(`WDTW_ADDR_RESET_CTRL, 16'h0000);
    rd_chk(`WDTW_ADDR_RESET_CTRL, 16'h0000);
    // Idle entry and another wake source each restart the count.
    arm(8'h40);
    repeat (60) @(posedge ref_clk);
    pulse(IDL);
    rd(`WDTW_ADDR_RESET_CTRL);
    chk(v[2], 1, v[2] === 1'b1);
    repeat (60) @(posedge ref_clk);
    pulse(WAKE);
    wait_ev(0, 128);
    // A completed clock switch restarts the count.
    arm(8'h40);
    repeat (100) @(posedge ref_clk);
    pulse(CSW);
    wait_ev(0, 128);
    // The hard enable runs the watchdog with the soft bit clear.
    wr(`WDTW_ADDR_RESET_CTRL, 16'h0000);
    wr(`WDTW_ADDR_CONFIG, 16'h00c0);
    wait_ev(0, 128);
    wr(`WDTW_ADDR_CONFIG, 16'h0040);
    repeat (2) @(posedge ref_clk);
    #1 chk(osc_o, 0, osc_o === 1'b0);
    // A device reset in mid-run clears the soft enable.
    arm(8'h40);
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    rd_chk(`WDTW_ADDR_RESET_CTRL, 16'h0000);
    chk(osc_o, 0, osc_o === 1'b0);
    rd_chk(`WDTW_ADDR_CONFIG, 16'h005f);
    end_of_test();
  end
endmodule
